// ===== design/csg_status_top.sv
// Top of the questionable and call state status groups with the
// command port that a status command parser drives.
// Assumes the parser, indicators and calibration summary share clk_sys_i,
// so none of these inputs is synchronised here.
`default_nettype none

module csg_status_top
    import csg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Decoded status command
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_group_i,
    input wire logic [2:0] cmd_reg_i,
    input wire logic [15:0] cmd_wdata_i,
    // Clear-status common command strobe
    input wire logic clear_status_i,
    // Call subsystem state indicators
    input wire logic call_connect_i,
    input wire logic call_access_i,
    input wire logic call_page_i,
    input wire logic call_register_i,
    input wire logic call_active_i,
    // Calibration group summary
    input wire logic cal_summary_i,
    // Query answer
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    // Group summaries
    output logic ques_summary_o,
    output logic call_summary_o
);

    // All state of the top: the answer register
    typedef struct packed {
        logic rsp_valid;
        logic [15:0] rsp_data;
    } csg_top_s;

    localparam csg_top_s TOP_RST = '{rsp_valid: 1'b0, rsp_data: RST_RDATA};

    csg_top_s state_q; // Registered answer
    csg_top_s state_d; // Next answer
    logic [15:0] call_cond_raw; // Call condition before the group
    logic [15:0] ques_cond_raw; // Questionable condition before the group
    logic ques_wr; // Write strobe to questionable group
    logic ques_rd; // Query strobe to questionable group
    logic call_wr; // Write strobe to call group
    logic call_rd; // Query strobe to call group
    logic [15:0] ques_rdata; // Questionable read value
    logic [15:0] call_rdata; // Call read value
    logic [15:0] ques_cond; // Questionable registered condition
    logic [15:0] call_cond; // Call registered condition

    // Condition assembly and command decode
    always_comb
    begin
        call_cond_raw = 16'h0000;
        call_cond_raw[CALL_CONNECT_BIT] = call_connect_i;
        call_cond_raw[CALL_ACCESS_BIT] = call_access_i;
        call_cond_raw[CALL_PAGE_BIT] = call_page_i;
        call_cond_raw[CALL_REGISTER_BIT] = call_register_i;
        call_cond_raw[CALL_ACTIVE_BIT] = call_active_i;
        ques_cond_raw = 16'h0000;
        ques_cond_raw[QUES_CAL_BIT] = cal_summary_i;
        // Strobes reach only the selected group
        ques_wr = cmd_valid_i && cmd_write_i && cmd_group_i == GRP_QUES;
        call_wr = cmd_valid_i && cmd_write_i && cmd_group_i == GRP_CALL;
        ques_rd = cmd_valid_i && !cmd_write_i && cmd_group_i == GRP_QUES;
        call_rd = cmd_valid_i && !cmd_write_i && cmd_group_i == GRP_CALL;
    end

    // Answer: one cycle after each query, writes get no answer
    always_comb
    begin
        state_d = state_q;
        state_d.rsp_valid = cmd_valid_i && !cmd_write_i;
        if (cmd_valid_i && !cmd_write_i)
        begin
            // Sampled before any clear that the same query causes
            state_d.rsp_data = (cmd_group_i == GRP_CALL) ? call_rdata : ques_rdata;
        end
    end

    // Answer register
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= TOP_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign rsp_valid_o = state_q.rsp_valid;
    assign rsp_data_o = state_q.rsp_data;

    csg_event_group #(
        .USED_MASK(QUES_USED_MASK)
    ) u_ques_group (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cond_i(ques_cond_raw),
        .wr_i(ques_wr),
        .rd_i(ques_rd),
        .sel_i(cmd_reg_i),
        .wdata_i(cmd_wdata_i),
        .cls_i(clear_status_i),
        .rdata_o(ques_rdata),
        .cond_o(ques_cond),
        .summary_o(ques_summary_o)
    );

    csg_event_group #(
        .USED_MASK(CALL_USED_MASK)
    ) u_call_group (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cond_i(call_cond_raw),
        .wr_i(call_wr),
        .rd_i(call_rd),
        .sel_i(cmd_reg_i),
        .wdata_i(cmd_wdata_i),
        .cls_i(clear_status_i),
        .rdata_o(call_rdata),
        .cond_o(call_cond),
        .summary_o(call_summary_o)
    );

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Query sequences used by the answer checks
    sequence s_call_query(logic [2:0] r);
        cmd_valid_i && !cmd_write_i && cmd_group_i == GRP_CALL && cmd_reg_i == r;
    endsequence

    sequence s_ques_query(logic [2:0] r);
        cmd_valid_i && !cmd_write_i && cmd_group_i == GRP_QUES && cmd_reg_i == r;
    endsequence

    // Repeat event query with the condition unchanged at its edge
    sequence s_quiet_ques_event;
        cmd_valid_i && !cmd_write_i && cmd_group_i == GRP_QUES && cmd_reg_i == REG_EVENT
            && $stable(ques_cond);
    endsequence

    // Condition indicators appear one cycle later
    a_connect_bit: assert property (call_cond[CALL_CONNECT_BIT] == $past(call_connect_i)
        && call_cond[CALL_ACCESS_BIT] == $past(call_access_i))
        else $error("connect or access bit wrong");
    a_page_bit: assert property (call_cond[CALL_PAGE_BIT] == $past(call_page_i))
        else $error("page bit wrong");
    a_access_bit: assert property (call_cond[CALL_ACCESS_BIT] == $past(call_access_i))
        else $error("access bit wrong");
    a_register_bit: assert property (call_cond[CALL_REGISTER_BIT] ==
        $past(call_register_i))
        else $error("registration bit wrong");
    a_active_bit: assert property (call_cond[CALL_ACTIVE_BIT] == $past(call_active_i))
        else $error("active bit wrong");
    a_cal_bit: assert property (ques_cond[QUES_CAL_BIT] == $past(cal_summary_i))
        else $error("calibration summary bit wrong");

    // Call condition query answers the registered condition
    a_cond_query: assert property (s_call_query(REG_COND) |=> rsp_valid_o
        && rsp_data_o == $past(call_cond))
        else $error("condition query answer wrong");
    // Event query clears, so a quiet repeat query reads zero
    a_event_query: assert property (s_ques_query(REG_EVENT) ##1 $stable(ques_cond)
        ##1 s_quiet_ques_event |=> rsp_valid_o && rsp_data_o == 16'h0000)
        else $error("event query not cleared");
    // Enable write reads back on a query two cycles later
    a_enable_back: assert property ((ques_wr && cmd_reg_i == REG_ENABLE) ##1 !ques_wr
        ##1 s_ques_query(REG_ENABLE) |=> rsp_data_o == $past(cmd_wdata_i, 3))
        else $error("enable readback wrong");
    // Filter write reads back on a query two cycles later
    a_ptr_back: assert property ((call_wr && cmd_reg_i == REG_PTR) ##1 !call_wr
        ##1 s_call_query(REG_PTR) |=> rsp_data_o == $past(cmd_wdata_i, 3))
        else $error("filter readback wrong");
    // Writes draw no answer
    a_write_silent: assert property ((cmd_valid_i && cmd_write_i) |=> !rsp_valid_o)
        else $error("answer to a write");
    // Every query draws an answer in the next cycle
    a_query_answer: assert property ((cmd_valid_i && !cmd_write_i) |=> rsp_valid_o)
        else $error("query not answered");
    // Unknown selects answer zero
    a_unmapped_zero: assert property ((cmd_valid_i && !cmd_write_i && cmd_reg_i > REG_ENABLE)
        |=> rsp_data_o == 16'h0000)
        else $error("unknown select answered nonzero");
    // Reserved bit never answered as set on condition query
    a_rsvd_answer: assert property (s_call_query(REG_COND) or s_ques_query(REG_COND)
        |=> !rsp_data_o[RSVD_BIT])
        else $error("reserved bit answered set");

endmodule

`default_nettype wire

// ===== design/csg_pkg.sv
// Shared constants for the call state and questionable status groups.
// Assumes a command parser upstream that decodes status commands into
// a group select, a register select, a write flag and a 16-bit value.
`default_nettype none

package csg_pkg;

    // Width of every status register
    localparam int unsigned WORD_W = 16;

    // Group select codes on the command port
    localparam logic GRP_QUES = 1'b0;
    localparam logic GRP_CALL = 1'b1;

    // Register select codes on the command port
    localparam logic [2:0] REG_COND = 3'h0;
    localparam logic [2:0] REG_PTR = 3'h1;
    localparam logic [2:0] REG_NTR = 3'h2;
    localparam logic [2:0] REG_EVENT = 3'h3;
    localparam logic [2:0] REG_ENABLE = 3'h4;

    // Reserved top bit, always zero in every condition register
    localparam int unsigned RSVD_BIT = 15;

    // Call state condition bit positions
    localparam int unsigned CALL_CONNECT_BIT = 5;
    localparam int unsigned CALL_ACCESS_BIT = 4;
    localparam int unsigned CALL_PAGE_BIT = 3;
    localparam int unsigned CALL_REGISTER_BIT = 1;
    localparam int unsigned CALL_ACTIVE_BIT = 0;

    // Questionable condition bit carrying the calibration summary
    localparam int unsigned QUES_CAL_BIT = 8;

    // Bits that exist in each group; all others read zero in the condition and event registers
    localparam logic [15:0] CALL_USED_MASK = 16'h003b;
    localparam logic [15:0] QUES_USED_MASK = 16'h0100;

    // Values after reset
    localparam logic [15:0] RST_COND = 16'h0000;
    localparam logic [15:0] RST_PTR = 16'hffff;
    localparam logic [15:0] RST_NTR = 16'h0000;
    localparam logic [15:0] RST_EVENT = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_RDATA = 16'h0000;

endpackage

`default_nettype wire

// ===== design/csg_event_group.sv
// One status group: condition, two transition filters, sticky event
// register, enable mask and a registered summary bit.
// Assumes strobes wr_i and rd_i last one cycle and come from the same clock.
`default_nettype none

module csg_event_group
    import csg_pkg::*;
#(
    parameter logic [15:0] USED_MASK = 16'h0000
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Live condition levels from the subsystem
    input wire logic [15:0] cond_i,
    // Register access from the command decoder
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [2:0] sel_i,
    input wire logic [15:0] wdata_i,
    input wire logic cls_i,
    // Read value and status
    output logic [15:0] rdata_o,
    output logic [15:0] cond_o,
    output logic summary_o
);

    // All state of the group
    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] event_r;
        logic [15:0] enable;
        logic summary;
    } csg_group_s;

    localparam csg_group_s GROUP_RST = '{cond: RST_COND, ptr: RST_PTR, ntr: RST_NTR,
        event_r: RST_EVENT, enable: RST_ENABLE, summary: 1'b0};

    csg_group_s state_q; // Registered state
    csg_group_s state_d; // Next state
    logic [15:0] cond_new; // Masked condition for this cycle
    logic [15:0] hits; // Edges that pass a filter
    logic clr; // Event clear request

    // Bits that pass a filter on a rise or a fall
    function automatic logic [15:0] csg_edge_hits(input logic [15:0] old_v,
        input logic [15:0] new_v, input logic [15:0] pf, input logic [15:0] nf);
        return (new_v & ~old_v & pf) | (~new_v & old_v & nf);
    endfunction

    // Next state of the group
    always_comb
    begin
        state_d = state_q;
        cond_new = cond_i & USED_MASK;
        cond_new[RSVD_BIT] = 1'b0;
        state_d.cond = cond_new;
        hits = csg_edge_hits(state_q.cond, cond_new, state_q.ptr, state_q.ntr) & USED_MASK;
        if (wr_i && sel_i == REG_PTR)
        begin
            state_d.ptr = wdata_i;
        end
        if (wr_i && sel_i == REG_NTR)
        begin
            state_d.ntr = wdata_i;
        end
        if (wr_i && sel_i == REG_ENABLE)
        begin
            state_d.enable = wdata_i;
        end
        clr = (rd_i && sel_i == REG_EVENT) || cls_i;
        state_d.event_r = (clr ? RST_EVENT : state_q.event_r) | hits;
        state_d.summary = |(state_d.event_r & state_d.enable);
    end

    // Read mux; the event value seen is the one before the clear
    always_comb
    begin
        case (sel_i)
            REG_COND: rdata_o = state_q.cond;
            REG_PTR: rdata_o = state_q.ptr;
            REG_NTR: rdata_o = state_q.ntr;
            REG_EVENT: rdata_o = state_q.event_r;
            REG_ENABLE: rdata_o = state_q.enable;
            // Unknown select answers zero
            default: rdata_o = RST_RDATA;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= GROUP_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign cond_o = state_q.cond;
    assign summary_o = state_q.summary;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Event query or clear-status keeps only fresh hits
    a_event_clear_read: assert property (clr |=> state_q.event_r == $past(hits))
        else $error("event register not cleared");
    // Latched bits stay until a clear
    a_event_sticky: assert property (!clr |=> (state_q.event_r & $past(state_q.event_r))
        == $past(state_q.event_r))
        else $error("event bit dropped without clear");
    // A filtered edge lands in the event register
    a_edge_latch: assert property ((|hits) |=> (state_q.event_r & $past(hits))
        == $past(hits))
        else $error("filtered edge not latched");
    // Summary follows enabled events
    a_summary_or: assert property (summary_o == |(state_q.event_r & state_q.enable))
        else $error("summary mismatch");
    // Unused and reserved bits stay zero
    a_unused_zero: assert property (((state_q.cond | state_q.event_r) & ~USED_MASK) == 16'h0000
        && !state_q.cond[RSVD_BIT])
        else $error("unused bit set");
    // Writing zero to the enable clears it by the next cycle
    a_enable_zero: assert property ((wr_i && sel_i == REG_ENABLE && wdata_i == 16'h0000)
        ##1 !(wr_i && sel_i == REG_ENABLE) |-> state_q.enable == 16'h0000)
        else $error("enable not cleared by zero write");
    // Negative filter writes are stored
    a_filter_store: assert property ((wr_i && sel_i == REG_NTR) |=>
        state_q.ntr == $past(wdata_i))
        else $error("negative filter not stored");

endmodule

`default_nettype wire

// ===== dv/csg_ctrl_model.sv
// Controller model: issues decoded status commands and collects answers.
// Assumes the groups take a command at a rising edge and answer one cycle later.
`default_nettype none

module csg_ctrl_model
    import csg_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Command port towards the groups
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic cmd_group_o,
    output logic [2:0] cmd_reg_o,
    output logic [15:0] cmd_wdata_o,
    // Answer from the groups
    input wire logic rsp_valid_i,
    input wire logic [15:0] rsp_data_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port at time zero
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_group_o = 1'b0;
        cmd_reg_o = 3'h0;
        cmd_wdata_o = 16'h0000;
    end

    // One command; qualifiers held up to the taking edge
    task automatic issue(input logic wr, input logic grp, input logic [2:0] sel,
        input logic [15:0] data);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= wr;
        cmd_group_o <= grp;
        cmd_reg_o <= sel;
        cmd_wdata_o <= data;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        // Scramble the write flag and data so stale values are never trusted
        cmd_write_o <= ~wr;
        cmd_wdata_o <= ~data;
    endtask

    // Plain register write
    task automatic write_reg(input logic grp, input logic [2:0] sel, input logic [15:0] data);
        issue(1'b1, grp, sel, data);
    endtask

    task automatic clear_enable(input logic grp);
        issue(1'b1, grp, REG_ENABLE, 16'h0000);
    endtask

    // Query; answer stands in the cycle after the taking edge
    task automatic query(input logic grp, input logic [2:0] sel, output logic vld,
        output logic [15:0] data);
        issue(1'b0, grp, sel, 16'h0000);
        @(negedge clk_sys_i);
        vld = rsp_valid_i;
        data = rsp_data_i;
    endtask
endmodule

`default_nettype wire

// ===== dv/call_and_quality_status_groups_tb_top.sv
// Bench for both status groups: command sequences with expected values.
// Assumes the controller model drives the command port for the bench.
`default_nettype none

module call_and_quality_status_groups_tb_top import csg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and clear-status strobe
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic clear_status_i = 1'b0;
    // Indicators, bit 0 up: active, register, page, access, connect
    logic [4:0] call_ind = 5'h00;
    logic cal_summary_i = 1'b0;
    // Command and answer wires
    logic cmd_valid, cmd_write, cmd_group, rsp_valid, ques_sum, call_sum;
    logic [2:0] cmd_reg;
    logic [15:0] cmd_wdata, rsp_data;
    int n_fail = 0;
    int n_compared = 0;
    // Condition bit of each indicator
    int unsigned ind_bit [5] = '{CALL_ACTIVE_BIT, CALL_REGISTER_BIT, CALL_PAGE_BIT,
        CALL_ACCESS_BIT, CALL_CONNECT_BIT};

    // Half period of 25 ns for 20 MHz
    always #25 clk_sys_i = ~clk_sys_i;

    csg_ctrl_model ctrl (.clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid),
        .cmd_write_o(cmd_write), .cmd_group_o(cmd_group), .cmd_reg_o(cmd_reg),
        .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data));

    csg_status_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
        .cmd_write_i(cmd_write), .cmd_group_i(cmd_group), .cmd_reg_i(cmd_reg),
        .cmd_wdata_i(cmd_wdata), .clear_status_i(clear_status_i),
        .call_connect_i(call_ind[4]), .call_access_i(call_ind[3]),
        .call_page_i(call_ind[2]), .call_register_i(call_ind[1]),
        .call_active_i(call_ind[0]), .cal_summary_i(cal_summary_i),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .ques_summary_o(ques_sum), .call_summary_o(call_sum));

    // Single comparison point
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Query and compare, answer strobe included
    task automatic qchk(input logic grp, input logic [2:0] sel, input logic [15:0] exp,
        input string what);
        logic vld;
        logic [15:0] d;
        ctrl.query(grp, sel, vld, d);
        chk({15'h0000, vld}, 16'h0001, "answer strobe");
        chk(d, exp, what);
    endtask

    // Let n edges pass, then sample mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    // Counts, verdict and end of run
    task automatic tally_and_finish;
        $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #(4000 * 50);
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        // Reset values, writes and refusals in both groups
        for (logic [1:0] g = 2'h0; g < 2'h2; g++)
        begin
            qchk(g[0], REG_COND, 16'h0000, "cond reset");
            qchk(g[0], REG_PTR, RST_PTR, "ptr reset");
            qchk(g[0], REG_NTR, RST_NTR, "ntr reset");
            qchk(g[0], REG_EVENT, 16'h0000, "event reset");
            qchk(g[0], REG_ENABLE, 16'h0000, "enable reset");
            qchk(g[0], 3'h5, 16'h0000, "unmapped select");
            ctrl.write_reg(g[0], REG_PTR, 16'ha5c3);
            ctrl.write_reg(g[0], REG_NTR, 16'h5a3c);
            ctrl.write_reg(g[0], REG_ENABLE, 16'h8001);
            ctrl.write_reg(g[0], REG_COND, 16'hffff);
            ctrl.write_reg(g[0], REG_EVENT, 16'hffff);
            qchk(g[0], REG_PTR, 16'ha5c3, "ptr readback");
            qchk(g[0], REG_NTR, 16'h5a3c, "ntr readback");
            qchk(g[0], REG_ENABLE, 16'h8001, "enable readback");
            qchk(g[0], REG_COND, 16'h0000, "cond write ignored");
            qchk(g[0], REG_EVENT, 16'h0000, "event write ignored");
            ctrl.clear_enable(g[0]);
            qchk(g[0], REG_ENABLE, 16'h0000, "enable cleared");
        end
        $display("Test registers done");
        // Each indicator alone, then all together
        ctrl.write_reg(GRP_CALL, REG_PTR, 16'hffff);
        qchk(GRP_CALL, REG_PTR, 16'hffff, "ptr rewrite");
        ctrl.write_reg(GRP_CALL, REG_NTR, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys_i);
            call_ind <= 5'h01 << i;
            settle(1);
            qchk(GRP_CALL, REG_COND, 16'h0001 << ind_bit[i], "cond bit");
        end
        @(posedge clk_sys_i);
        call_ind <= 5'h1f;
        qchk(GRP_CALL, REG_COND, 16'h003b, "cond all on");
        qchk(GRP_CALL, REG_EVENT, 16'h003b, "rises latched");
        qchk(GRP_CALL, REG_EVENT, 16'h0000, "cleared by query");
        $display("Test call conditions done");
        // Falling edge filter, summary and clear-status
        ctrl.write_reg(GRP_CALL, REG_PTR, 16'h0000);
        ctrl.write_reg(GRP_CALL, REG_NTR, 16'h0001);
        ctrl.write_reg(GRP_CALL, REG_ENABLE, 16'h0001);
        @(posedge clk_sys_i);
        call_ind <= 5'h00;
        settle(1);
        chk({15'h0000, call_sum}, 16'h0001, "summary on fall");
        @(posedge clk_sys_i);
        clear_status_i <= 1'b1;
        @(posedge clk_sys_i);
        clear_status_i <= 1'b0;
        settle(1);
        chk({15'h0000, call_sum}, 16'h0000, "summary after clear");
        qchk(GRP_CALL, REG_EVENT, 16'h0000, "events after clear");
        @(posedge clk_sys_i);
        call_ind <= 5'h01;
        settle(2);
        chk({15'h0000, call_sum}, 16'h0000, "rise filtered out");
        @(posedge clk_sys_i);
        call_ind <= 5'h00;
        settle(2);
        ctrl.write_reg(GRP_CALL, REG_ENABLE, 16'h0000);
        settle(0);
        chk({15'h0000, call_sum}, 16'h0000, "summary masked");
        qchk(GRP_CALL, REG_EVENT, 16'h0001, "fall latched");
        $display("Test call events done");
        // Calibration summary in the questionable group
        ctrl.write_reg(GRP_QUES, REG_PTR, 16'h0100);
        ctrl.write_reg(GRP_QUES, REG_ENABLE, 16'h0100);
        cal_summary_i <= 1'b1;
        settle(2);
        chk({15'h0000, ques_sum}, 16'h0001, "ques summary");
        qchk(GRP_QUES, REG_COND, 16'h0100, "ques cond");
        qchk(GRP_QUES, REG_EVENT, 16'h0100, "ques event");
        qchk(GRP_QUES, REG_EVENT, 16'h0000, "ques cleared");
        chk({15'h0000, ques_sum}, 16'h0000, "ques summary off");
        $display("Test questionable done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
